// *** hw/qsw_link_if.sv ***
// Purpose: carries words and frame bookkeeping between core and link domains
// Assumes: txWord is frozen by the core while chip select is low
// Notes:   link-side signals only change on serial clock edges inside frames
`timescale 1ns/1ps
interface qsw_link_if;
   import qsw_pkg::*;
   logic [WORD_W-1:0] txWord;
   logic [WORD_W-1:0] rxWord;
   logic [CNT_W-1:0]  bitCnt;
   logic              frameTgl;
   modport core (output txWord, input rxWord, input bitCnt, input frameTgl);
   modport link (input txWord, output rxWord, output bitCnt, output frameTgl);
endinterface

// *** hw/qsw_pkg.sv ***
// Purpose: shared constants and types for the quad switch status word block
// Assumes: 16-bit frames, four high-side outputs, five-bit readback selector
// Notes:   selector codes for output-independent sources equal the register offsets
package qsw_pkg;
   localparam int WORD_W      = 16;
   localparam int CNT_W       = 4;
   localparam int NUM_OUT     = 4;
   localparam int SEL_W       = 5;
   localparam int SYNC_W      = 27;

   // returned word layout
   localparam int SO_WD_BIT   = 15;
   localparam int SO_UV_BIT   = 14;
   localparam int SO_OV_BIT   = 13;
   localparam int SO_SEL_HI   = 12;
   localparam int SO_SEL_LO   = 8;
   localparam int SO_ST_HI    = 7;
   localparam int SO_ST_LO    = 4;

   // incoming command layout
   localparam int CMD_WD_BIT  = 15;
   localparam int CMD_ADDR_HI = 10;
   localparam int CMD_ADDR_LO = 8;
   localparam int CMD_SEL_HI  = 4;
   localparam int CMD_SEL_LO  = 0;
   localparam logic [2:0] CMD_ADDR_STATUS = 3'h0;

   // output-specific sources, low three selector bits
   localparam logic [2:0] SRC_FAULT  = 3'h0;
   localparam logic [2:0] SRC_LEVEL  = 3'h2;
   localparam logic [2:0] SRC_BLANK  = 3'h3;
   localparam logic [2:0] SRC_DIRECT = 3'h4;

   // output-independent sources, full selector
   localparam logic [4:0] REG_OUTPUT_ON_COMMAND       = 5'h01;
   localparam logic [4:0] REG_SUPPLY_PROTECT_CONFIG   = 5'h05;
   localparam logic [4:0] REG_PIN_FAILSAFE_STATE      = 5'h06;
   localparam logic [4:0] REG_CURRENT_SENSE_ENABLE    = 5'h09;
   localparam logic [4:0] REG_WATCHDOG_CONFIG         = 5'h0d;
   localparam logic [4:0] REG_DIRECT_INPUT_LEVELS     = 5'h0e;
   localparam logic [4:0] REG_OVERTEMP_LATCH_READBACK = 5'h0f;

   // reset values
   localparam logic [4:0]  SEL_RESET  = 5'h00;
   localparam logic [15:0] WORD_RESET = 16'h0000;
   localparam logic [3:0]  CNT_ONE    = 4'h1;

   typedef enum logic [1:0] {
      FR_IDLE   = 2'b00,
      FR_ACTIVE = 2'b01,
      FR_CLOSE  = 2'b10
   } qsw_frame_t;
endpackage

// *** hw/qsw_spi_shifter.sv ***
// Purpose: serial-clock side shift register, bit counter and frame marker
// Assumes: data sampled on rising serial clock, chip select low during frame
// Notes:   serial data out changes just after each rising edge
`timescale 1ns/1ps
module qsw_spi_shifter import qsw_pkg::*; (
   input  wire logic sclk,
   input  wire logic rst_b,
   input  wire logic csPin_b,
   input  wire logic serialIn,
   output logic      soBit,
   qsw_link_if.link  lnk
);
   logic              armClr;
   logic              armed_q;
   logic [WORD_W-1:0] shift_q;
   logic [CNT_W-1:0]  cnt_q;
   logic              tgl_q;
   logic [WORD_W-1:0] shiftSrc;

   // clock stops between frames, so the frame's own select ends it
   assign armClr   = csPin_b | ~rst_b;
   assign shiftSrc = armed_q ? shift_q : lnk.txWord;
   // msb is visible before the first edge; the other 15 word bits follow, then bits echo serialIn
   assign soBit    = armed_q ? shift_q[WORD_W-1] : lnk.txWord[WORD_W-1];

   always_ff @(posedge sclk or posedge armClr) begin
      if (armClr) begin
         armed_q <= 1'b0;
      end else begin
         armed_q <= 1'b1;
      end
   end

   always_ff @(posedge sclk or negedge rst_b) begin
      if (!rst_b) begin
         shift_q <= WORD_RESET;
         cnt_q   <= '0;
         tgl_q   <= 1'b0;
      end else begin
         shift_q <= {shiftSrc[WORD_W-2:0], serialIn};
         cnt_q   <= armed_q ? cnt_q + 1'b1 : CNT_ONE;
         if (!armed_q) begin
            tgl_q <= ~tgl_q;
         end
      end
   end

   assign lnk.rxWord   = shift_q;
   assign lnk.bitCnt   = cnt_q;
   assign lnk.frameTgl = tgl_q;
endmodule

// *** hw/qsw_status_word.sv ***
// Purpose: builds and returns the 16-bit status word of the quad switch serial port
// Assumes: config fields come from the register file on mclk; fault and pin inputs are asynchronous
// Notes:   leave at least 30 ns between chip select falling and the first serial clock edge
`timescale 1ns/1ps
module qsw_status_word import qsw_pkg::*; (
   input  wire logic                 mclk,
   input  wire logic                 rst_b,
   input  wire logic                 sclk,
   input  wire logic                 csPin_b,
   input  wire logic                 serialIn,
   output logic                      soData,
   output logic                      soOe,
   output logic                      faultIndicator_b,
   output logic                      faultIndicatorOe,
   output logic [SEL_W-1:0]          readbackSelector,
   input  wire logic                 undervoltageEvent,
   input  wire logic                 overvoltageEvent,
   input  wire logic [NUM_OUT-1:0]   overtempFault,
   input  wire logic [NUM_OUT-1:0]   highOvercurrentFault,
   input  wire logic [NUM_OUT-1:0]   lowOvercurrentFault,
   input  wire logic [NUM_OUT-1:0]   openLoadFault,
   input  wire logic [NUM_OUT-1:0]   directInputPin,
   input  wire logic                 wakePin,
   input  wire logic [1:0]           failsafeOutputState,
   input  wire logic [NUM_OUT-1:0]   serialOnBit,
   input  wire logic [NUM_OUT-1:0]   senseEnable_b,
   input  wire logic [NUM_OUT-1:0]   highCurrentLevel,
   input  wire logic [3*NUM_OUT-1:0] lowCurrentLevel,
   input  wire logic [NUM_OUT-1:0]   openLoadDisable,
   input  wire logic [NUM_OUT-1:0]   lowOvercurrentDisable,
   input  wire logic [2*NUM_OUT-1:0] blankingTimeCode,
   input  wire logic [NUM_OUT-1:0]   fastSlewSelect,
   input  wire logic [NUM_OUT-1:0]   highSenseRatioSelect,
   input  wire logic [NUM_OUT-1:0]   directControlDisable,
   input  wire logic [NUM_OUT-1:0]   andOrCombine,
   input  wire logic [NUM_OUT-1:0]   overtempLatchSetting,
   input  wire logic                 undervoltageDisable,
   input  wire logic                 overvoltageDisable,
   input  wire logic [1:0]           watchdogPeriodCode,
   input  wire logic                 watchdogEnabled,
   input  wire logic                 watchdogExpired
);
   if (WORD_W != 16 || NUM_OUT != 4 || SEL_W != 5) begin : g_bad
      $error("qsw_status_word supports only a 16-bit word with four outputs");
   end

   qsw_link_if lnk ();

   // ---------------------------------------------------------------
   // synchronised pins: {cs, tgl, wake, failsafe, direct, ot, hoc, loc, ol, uv, ov}
   // ---------------------------------------------------------------
   logic [SYNC_W-1:0] rawIn;
   logic [SYNC_W-1:0] syncIn;
   logic              csS;
   logic              tglS;
   logic              wakeS;
   logic [1:0]        fsStateS;
   logic [3:0]        dirS;
   logic [3:0]        otS;
   logic [3:0]        hocS;
   logic [3:0]        locS;
   logic [3:0]        olS;
   logic              uvS;
   logic              ovS;

   assign rawIn = {csPin_b, lnk.frameTgl, wakePin, failsafeOutputState, directInputPin,
                   overtempFault, highOvercurrentFault, lowOvercurrentFault, openLoadFault,
                   undervoltageEvent, overvoltageEvent};

   // chip select idles high so reset must not fake a frame
   qsw_sync2 #(
      .W       (SYNC_W),
      .RST_VAL ({1'b1, {(SYNC_W-1){1'b0}}})
   ) u_sync (
      .mclk    (mclk),
      .rst_b   (rst_b),
      .asyncIn (rawIn),
      .syncOut (syncIn)
   );

   assign {csS, tglS, wakeS, fsStateS, dirS, otS, hocS, locS, olS, uvS, ovS} = syncIn;

   qsw_spi_shifter u_shift (
      .sclk     (sclk),
      .rst_b    (rst_b),
      .csPin_b  (csPin_b),
      .serialIn (serialIn),
      .soBit    (soData),
      .lnk      (lnk.link)
   );

   // ---------------------------------------------------------------
   // frame tracking
   // ---------------------------------------------------------------
   qsw_frame_t        state_q;
   qsw_frame_t        state_d;
   logic              tglSeen_q;
   logic              hadBits;
   logic              lenOk;
   logic              frameOk;
   logic [WORD_W-1:0] cmd;
   logic              cmdIsStatus;

   always_comb begin
      state_d = state_q;
      case (state_q)
         FR_IDLE: begin
            if (!csS) begin
               state_d = FR_ACTIVE;
            end
         end
         FR_ACTIVE: begin
            if (csS) begin
               state_d = FR_CLOSE;
            end
         end
         FR_CLOSE: begin
            state_d = FR_IDLE;
         end
         default: begin
            state_d = FR_IDLE;
         end
      endcase
   end

   // link values are stable here: serial clock has stopped with the frame
   assign hadBits     = tglS != tglSeen_q;
   assign lenOk       = lnk.bitCnt == '0;
   assign frameOk     = (state_q == FR_CLOSE) && hadBits && lenOk;
   assign cmd         = lnk.rxWord;
   assign cmdIsStatus = cmd[CMD_ADDR_HI:CMD_ADDR_LO] == CMD_ADDR_STATUS;

   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         state_q   <= FR_IDLE;
         tglSeen_q <= 1'b0;
      end else begin
         state_q <= state_d;
         if (state_q == FR_CLOSE) begin
            tglSeen_q <= tglS;
         end
      end
   end

   // ---------------------------------------------------------------
   // command-derived state, changed only by accepted frames
   // ---------------------------------------------------------------
   logic             wdEcho_q;
   logic             wdEcho_d;
   logic [SEL_W-1:0] sel_q;
   logic [SEL_W-1:0] sel_d;

   assign wdEcho_d = frameOk ? cmd[CMD_WD_BIT] : wdEcho_q;
   assign sel_d    = (frameOk && cmdIsStatus) ? cmd[CMD_SEL_HI:CMD_SEL_LO] : sel_q;

   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         wdEcho_q <= 1'b0;
         sel_q    <= SEL_RESET;
      end else begin
         wdEcho_q <= wdEcho_d;
         sel_q    <= sel_d;
      end
   end

   // ---------------------------------------------------------------
   // supply flags: sticky until reported in an accepted frame
   // ---------------------------------------------------------------
   logic              uv_q;
   logic              ov_q;
   logic [WORD_W-1:0] word_q;
   logic              uvClr;
   logic              ovClr;

   // only a reported event is cleared; a new one wins the same cycle
   assign uvClr = frameOk & word_q[SO_UV_BIT];
   assign ovClr = frameOk & word_q[SO_OV_BIT];

   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         uv_q <= 1'b0;
         ov_q <= 1'b0;
      end else begin
         uv_q <= uvS | (uv_q & ~uvClr);
         ov_q <= ovS | (ov_q & ~ovClr);
      end
   end

   // ---------------------------------------------------------------
   // per-output fault latch and readback nibbles
   // ---------------------------------------------------------------
   logic [NUM_OUT-1:0] latch_q;
   logic [NUM_OUT-1:0] serOnPrev_q;
   logic [NUM_OUT-1:0] dirPrev_q;
   logic [NUM_OUT-1:0] offCmd;
   logic [NUM_OUT-1:0] summary;
   logic [3:0]         faultNib  [NUM_OUT];
   logic [3:0]         levelNib  [NUM_OUT];
   logic [3:0]         blankNib  [NUM_OUT];
   logic [3:0]         directNib [NUM_OUT];

   for (genvar i = 0; i < NUM_OUT; i++) begin : g_out
      // switch-off is a falling serial on bit or direct input
      assign offCmd[i]    = (serOnPrev_q[i] & ~serialOnBit[i]) | (dirPrev_q[i] & ~dirS[i]);
      assign summary[i]   = latch_q[i] | olS[i];
      assign faultNib[i]  = {otS[i], hocS[i], locS[i], olS[i]};
      assign levelNib[i]  = {highCurrentLevel[i], lowCurrentLevel[3*i +: 3]};
      assign blankNib[i]  = {openLoadDisable[i], lowOvercurrentDisable[i], blankingTimeCode[2*i +: 2]};
      assign directNib[i] = {fastSlewSelect[i], highSenseRatioSelect[i],
                             directControlDisable[i], andOrCombine[i]};

      always_ff @(posedge mclk) begin
         if (!rst_b) begin
            latch_q[i]     <= 1'b0;
            serOnPrev_q[i] <= 1'b0;
            dirPrev_q[i]   <= 1'b0;
         end else begin
            // a fault present while switching off stays latched
            latch_q[i]     <= (otS[i] | hocS[i] | locS[i]) | (latch_q[i] & ~offCmd[i]);
            serOnPrev_q[i] <= serialOnBit[i];
            dirPrev_q[i]   <= dirS[i];
         end
      end
   end

   // ---------------------------------------------------------------
   // low nibble source selection
   // ---------------------------------------------------------------
   logic [1:0] selIdx;
   logic [2:0] selSrc;
   logic       isFault;
   logic       isLevel;
   logic       isBlank;
   logic       isDirect;
   logic       isOn;
   logic       isSense;
   logic       isSupply;
   logic       isWdog;
   logic       isPins;
   logic       isDirIn;
   logic       isOtHigh;
   logic [3:0] nibble;

   assign selIdx   = sel_q[4:3];
   assign selSrc   = sel_q[2:0];
   assign isFault  = selSrc == SRC_FAULT;
   assign isLevel  = selSrc == SRC_LEVEL;
   assign isBlank  = selSrc == SRC_BLANK;
   assign isDirect = selSrc == SRC_DIRECT;
   assign isOn     = sel_q == REG_OUTPUT_ON_COMMAND;
   assign isSense  = sel_q == REG_CURRENT_SENSE_ENABLE;
   assign isSupply = sel_q == REG_SUPPLY_PROTECT_CONFIG;
   assign isWdog   = sel_q == REG_WATCHDOG_CONFIG;
   assign isPins   = sel_q == REG_PIN_FAILSAFE_STATE;
   assign isDirIn  = sel_q == REG_DIRECT_INPUT_LEVELS;
   assign isOtHigh = sel_q == REG_OVERTEMP_LATCH_READBACK;

   assign nibble = isFault  ? faultNib[selIdx]  :
                   isLevel  ? levelNib[selIdx]  :
                   isBlank  ? blankNib[selIdx]  :
                   isDirect ? directNib[selIdx] :
                   isOn     ? serialOnBit       :
                   isSense  ? senseEnable_b     :
                   isSupply ? {overtempLatchSetting[1:0], undervoltageDisable, overvoltageDisable} :
                   isWdog   ? {1'b0, watchdogExpired, watchdogPeriodCode} :
                   isPins   ? {fsStateS, watchdogEnabled, wakeS} :
                   isDirIn  ? dirS              :
                   isOtHigh ? {overtempLatchSetting[3:2], 2'b00} :
                   4'h0;

   // ---------------------------------------------------------------
   // status word: tracks live state between frames, frozen inside one
   // ---------------------------------------------------------------
   logic [WORD_W-1:0] statusWord;
   logic              anyFault;

   assign statusWord = {wdEcho_q, uv_q, ov_q, sel_q, summary[3], summary[2], summary[1], summary[0],
                        nibble};
   assign anyFault   = (|latch_q) | (|olS) | uvS | ovS;

   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         word_q <= WORD_RESET;
      end else if (state_q == FR_IDLE && csS) begin
         word_q <= statusWord;
      end
   end

   assign lnk.txWord = word_q;

   // ---------------------------------------------------------------
   // pin drivers
   // ---------------------------------------------------------------
   logic faultInd_q;
   logic soOe_q;

   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         faultInd_q       <= 1'b0;
         soOe_q           <= 1'b0;
         readbackSelector <= SEL_RESET;
      end else begin
         faultInd_q       <= anyFault;
         // released as soon as chip select is seen high again
         soOe_q           <= ~csS;
         readbackSelector <= sel_q;
      end
   end

   // open drain: only ever pulls low
   assign faultIndicator_b = 1'b0;
   assign faultIndicatorOe = faultInd_q;
   assign soOe             = soOe_q;
endmodule

// *** hw/qsw_sync2.sv ***
// Purpose: two-flop synchroniser for a vector of unrelated levels
// Assumes: each bit is an independent slow level
// Notes:   first stage is read only by the second stage
`timescale 1ns/1ps
module qsw_sync2 import qsw_pkg::*; #(
   parameter int           W       = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input  wire logic         mclk,
   input  wire logic         rst_b,
   input  wire logic [W-1:0] asyncIn,
   output logic      [W-1:0] syncOut
);
   logic [W-1:0] meta_q;

   if (W < 1) begin : g_bad
      $error("qsw_sync2 needs at least one bit");
   end

   for (genvar i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge mclk) begin
         if (!rst_b) begin
            meta_q[i]  <= RST_VAL[i];
            syncOut[i] <= RST_VAL[i];
         end else begin
            meta_q[i]  <= asyncIn[i];
            syncOut[i] <= meta_q[i];
         end
      end
   end
endmodule

// *** verif/qsw_spi_master.sv ***
// Purpose: host master model driving the serial pins
// Assumes: 64 ns serial clock, only inside frames
// Notes:   released data line shows the inverse, not the last bit
`timescale 1ns/1ps
module qsw_spi_master (
   output logic      sclk,
   output logic      csPin_b,
   output logic      serialIn,
   input  wire logic soData
);
   initial begin
      sclk = 1'b0;
      csPin_b = 1'b1;
      serialIn = 1'b0;
   end
   task automatic xfer(input logic [31:0] tx, input int n, output logic [31:0] rx);
      rx = '0;
      csPin_b = 1'b0;
      #40;
      for (int i = n - 1; i >= 0; i--) begin
         serialIn = tx[i];
         #32;
         rx = {rx[30:0], soData};
         sclk = 1'b1;
         #32;
         sclk = 1'b0;
      end
      #20;
      csPin_b = 1'b1;
      serialIn = ~serialIn;
      // gap well above the six core cycles between frames
      #100;
   endtask
endmodule

// *** verif/qsw_status_word_checker.sv ***
// Purpose: port assertions for the status word block
// Assumes: bound by name to qsw_status_word
// Notes:   serial echo check counts edges inside each frame
`timescale 1ns/1ps
module qsw_status_word_checker import qsw_pkg::*; (
   input wire logic               mclk,
   input wire logic               rst_b,
   input wire logic               sclk,
   input wire logic               csPin_b,
   input wire logic               serialIn,
   input wire logic               soData,
   input wire logic               soOe,
   input wire logic               faultIndicator_b,
   input wire logic               faultIndicatorOe,
   input wire logic [SEL_W-1:0]   readbackSelector,
   input wire logic               undervoltageEvent,
   input wire logic [NUM_OUT-1:0] overtempFault
);
   logic [5:0] edgeCnt_q;
   // saturates so long daisy frames stay checked
   always_ff @(posedge sclk or posedge csPin_b or negedge rst_b) begin
      if (!rst_b || csPin_b) begin
         edgeCnt_q <= 6'h00;
      end else if (edgeCnt_q != 6'h3f) begin
         edgeCnt_q <= edgeCnt_q + 6'h01;
      end
   end
   AST_OE_ON: assert property (@(posedge mclk) disable iff (!rst_b)
      $fell(csPin_b) |-> ##[1:4] soOe) else $error("serial out not driven");
   AST_OE_OFF: assert property (@(posedge mclk) disable iff (!rst_b)
      $rose(csPin_b) |-> ##[1:4] !soOe) else $error("serial out not released");
   AST_SEL_CHANGE: assert property (@(posedge mclk) disable iff (!rst_b)
      $changed(readbackSelector) |-> csPin_b && $past(csPin_b, 3)) else $error("selector moved in frame");
   AST_ECHO: assert property (@(posedge sclk) disable iff (!rst_b || csPin_b)
      edgeCnt_q >= 6'h10 |-> soData == $past(serialIn, 16)) else $error("daisy echo wrong");
   AST_UV_PIN: assert property (@(posedge mclk) disable iff (!rst_b)
      undervoltageEvent [*3] |-> ##[0:4] faultIndicatorOe) else $error("fault pin missed undervoltage");
   AST_OT_PIN: assert property (@(posedge mclk) disable iff (!rst_b)
      (|overtempFault) [*3] |-> ##[0:4] faultIndicatorOe) else $error("fault pin missed overtemp");
   // pin output lags the raw event by three core edges
   AST_PIN_LEVEL: assert property (@(posedge mclk) disable iff (!rst_b)
      $fell(faultIndicatorOe) |-> !faultIndicator_b && !$past(undervoltageEvent, 3))
      else $error("fault pin released during undervoltage");
   AST_RESET_VAL: assert property (@(posedge mclk) disable iff (!rst_b)
      $rose(rst_b) |-> readbackSelector == SEL_RESET && !soOe && !faultIndicatorOe) else $error("bad reset state");
endmodule

// *** verif/qsw_status_word_tb_top.sv ***
// Purpose: self-checking bench for the status word block
// Assumes: master model drives the serial pins
// Notes:   expected words come from the bench's own input values
`timescale 1ns/1ps
module qsw_status_word_tb_top import qsw_pkg::*; ();
   logic        mclk, rst_b, sclk, csPin_b, serialIn, soData, soOe, faultIndicator_b, faultIndicatorOe;
   logic        undervoltageEvent, overvoltageEvent, wakePin, undervoltageDisable, overvoltageDisable;
   logic        watchdogEnabled, watchdogExpired, wdLast;
   logic [1:0]  failsafeOutputState, watchdogPeriodCode;
   logic [3:0]  overtempFault, highOvercurrentFault, lowOvercurrentFault, openLoadFault, directInputPin;
   logic [3:0]  serialOnBit, senseEnable_b, highCurrentLevel, openLoadDisable, lowOvercurrentDisable;
   logic [3:0]  fastSlewSelect, highSenseRatioSelect, directControlDisable, andOrCombine, overtempLatchSetting;
   logic [4:0]  readbackSelector, selLast;
   logic [7:0]  blankingTimeCode;
   logic [11:0] lowCurrentLevel;
   logic [31:0] rx;
   int          errors;
   int          checked;

   qsw_status_word dut (.*);
   qsw_spi_master master (.sclk(sclk), .csPin_b(csPin_b), .serialIn(serialIn), .soData(soData));

   initial mclk = 1'b0;
   always #5 mclk = ~mclk;

   task automatic close_out();
      if (errors == 0 && checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   task automatic check(input logic [15:0] got, input logic [15:0] want);
      checked++;
      if (got !== want) begin
         errors++;
         $display("MISMATCH %0t got %h want %h", $time, got, want);
      end
   endtask

   task automatic ticks(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask

   function automatic logic [3:0] nib(input logic [4:0] s);
      int o;
      o = int'(s[4:3]);
      if (s[2:0] == 3'h0) return {overtempFault[o], highOvercurrentFault[o], lowOvercurrentFault[o], openLoadFault[o]};
      if (s[2:0] == 3'h2) return {highCurrentLevel[o], lowCurrentLevel[3*o+:3]};
      if (s[2:0] == 3'h3) return {openLoadDisable[o], lowOvercurrentDisable[o], blankingTimeCode[2*o+:2]};
      if (s[2:0] == 3'h4) return {fastSlewSelect[o], highSenseRatioSelect[o], directControlDisable[o], andOrCombine[o]};
      case (s)
         5'h01: return serialOnBit;
         5'h09: return senseEnable_b;
         5'h05: return {overtempLatchSetting[1:0], undervoltageDisable, overvoltageDisable};
         5'h0d: return {1'b0, watchdogExpired, watchdogPeriodCode};
         5'h06: return {failsafeOutputState, watchdogEnabled, wakePin};
         5'h0e: return directInputPin;
         5'h0f: return {overtempLatchSetting[3:2], 2'b00};
         default: return 4'h0;
      endcase
   endfunction

   // status-select frame; judges the word left by the previous command
   task automatic frame(input logic wd, input logic [4:0] sel, input logic [3:0] st, input logic [1:0] uvov);
      logic [15:0] want;
      want = {wdLast, uvov, selLast, st, nib(selLast)};
      master.xfer({16'h0000, wd, 10'h000, sel}, 16, rx);
      check(rx[15:0], want);
      check({11'h000, readbackSelector}, {11'h000, sel});
      wdLast = wd;
      selLast = sel;
   endtask

   task automatic sweep_selectors();
      for (int i = 0; i < 33; i++) begin
         frame(i[0], i[4:0], 4'h0, 2'b00);
      end
   endtask

   task automatic bad_and_long_frames();
      logic [15:0] want;
      want = {wdLast, 2'b00, selLast, 4'h0, nib(selLast)};
      master.xfer({8'h00, 8'h5a, ~wdLast, 10'h000, 5'h0e}, 24, rx);
      check(rx[23:8], want);
      check({8'h00, rx[7:0]}, 16'h005a);
      frame(~wdLast, 5'h0e, 4'h0, 2'b00);
      want = {wdLast, 2'b00, selLast, 4'h0, nib(selLast)};
      master.xfer({16'hc3a5, ~wdLast, 10'h000, 5'h06}, 32, rx);
      check(rx[31:16], want);
      check(rx[15:0], 16'hc3a5);
      wdLast = ~wdLast;
      selLast = 5'h06;
      // a command for another address moves the echo but not the selector
      want = {wdLast, 2'b00, selLast, 4'h0, nib(selLast)};
      master.xfer({16'h0000, ~wdLast, 4'h0, 3'h1, 3'h0, 5'h01}, 16, rx);
      check(rx[15:0], want);
      wdLast = ~wdLast;
      frame(wdLast, 5'h06, 4'h0, 2'b00);
   endtask

   task automatic fault_path();
      ticks(1);
      serialOnBit = 4'hf;
      frame(1'b0, 5'h10, 4'h0, 2'b00);
      ticks(1);
      {overtempFault[2], highOvercurrentFault[2], lowOvercurrentFault[2], openLoadFault[1]} = 4'hf;
      {undervoltageEvent, overvoltageEvent} = 2'b11;
      ticks(10);
      {undervoltageEvent, overvoltageEvent} = 2'b00;
      ticks(2);
      check({15'h0000, faultIndicatorOe}, 16'h0001);
      frame(1'b1, 5'h10, 4'h6, 2'b11);
      ticks(1);
      {overtempFault[2], highOvercurrentFault[2], lowOvercurrentFault[2], openLoadFault[1]} = 4'h0;
      ticks(10);
      frame(1'b0, 5'h10, 4'h4, 2'b00);
      check({15'h0000, faultIndicatorOe}, 16'h0001);
      ticks(1);
      // falling serial on bit is the switch-off that frees the latch
      serialOnBit = 4'hb;
      ticks(10);
      check({15'h0000, faultIndicatorOe}, 16'h0000);
      frame(1'b1, 5'h10, 4'h0, 2'b00);
   endtask

   initial begin
      errors = 0;
      checked = 0;
      wdLast = 1'b0;
      selLast = SEL_RESET;
      rst_b = 1'b0;
      {undervoltageEvent, overvoltageEvent, overtempFault, highOvercurrentFault} = '0;
      {lowOvercurrentFault, openLoadFault} = 8'h00;
      {serialOnBit, senseEnable_b, highCurrentLevel, openLoadDisable} = 16'ha56d;
      {lowOvercurrentDisable, fastSlewSelect, highSenseRatioSelect, directControlDisable} = 16'h3c27;
      {andOrCombine, overtempLatchSetting, directInputPin, blankingTimeCode} = 20'he9d1b;
      lowCurrentLevel = 12'hb1e;
      {undervoltageDisable, overvoltageDisable, watchdogEnabled, watchdogExpired, wakePin} = 5'h1b;
      {failsafeOutputState, watchdogPeriodCode} = 4'h6;
      // synchronisers take their reset values at the first edge
      ticks(2);
      rst_b = 1'b1;
      ticks(6);
      sweep_selectors();
      bad_and_long_frames();
      fault_path();
      close_out();
   end

   initial begin
      #900000;
      errors++;
      close_out();
   end
endmodule

bind qsw_status_word qsw_status_word_checker chk (.*);
